// *** design/bmsrm_boot_map.sv ***
// Top: boot mode selection, boot ROM mapping, flash section and config write gating
//
// How it works
// - Mode sampled from two straps on every reset
// - Fetch strobe low, latch strobe high: serial
// - Fetch strobe high, latch strobe low: parallel
// - Both straps high: user application mode
// - Programming mode kept until normal-mode reset
// - Serial programming routed over serial port zero
// - Serial baud capped by oscillator-derived limit
// - User mode, ROM enabled: F800-FFFF hits ROM
// - Programming modes map ROM at lowest 2kB
// - ROM disabled: upper region never hits ROM
// - Flash split into four sections
// - Erased flash reads all ones
// - Flash writing code runs from ROM/RAM only
// - User mode may program code and data
// - Entry FFDF returns selected config byte
// - ROM enable is config byte zero bit 4
// - Config bytes writable only in programming mode
`timescale 1ns/1ps
`default_nettype none
module bmsrm_boot_map #(
  parameter int ADDR_W = bmsrm_pkg::BMSRM_ADDR_W,
  parameter logic [15:0] PROG_MEM_SIZE = 16'h8000,
  parameter int BAUD_DIV_MIN = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic addr_latch_strobe_i,
  input wire logic program_fetch_strobe_i,
  input wire logic [15:0] fetch_addr_i,
  input wire logic fetch_from_ram_i,
  input wire logic [6:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic cfg_we_i,
  input wire logic [7:0] cfg_rdata_i,
  input wire logic [15:0] flash_addr_i,
  input wire logic flash_we_i,
  input wire logic [15:0] baud_div_i,
  output bmsrm_pkg::bmsrm_mode_e mode_o,
  output logic user_application_mode_o,
  output logic serial_port_zero_prog_o,
  output logic reserved_strap_o,
  output logic rom_sel_o,
  output logic [10:0] rom_addr_o,
  output logic cfg_read_entry_o,
  output logic [7:0] cfg_read_data_o,
  output logic boot_rom_enable_bit_o,
  output logic cfg_we_o,
  output logic flash_we_o,
  output bmsrm_pkg::bmsrm_sect_e flash_sect_o,
  output logic baud_ok_o,
  output logic [7:0] erased_value_o
);
  import bmsrm_pkg::*;
  bmsrm_mode_e mode;
  logic reserved;
  logic prog_mode;
  logic [7:0] hw_config_byte_zero_r;
  logic [7:0] hw_config_byte_zero_nxt;
  logic [7:0] cfg_data_r;
  logic [7:0] cfg_data_nxt;
  logic hi_hit;
  logic lo_hit;

  bmsrm_strap_latch u_strap (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .addr_latch_strobe_i(addr_latch_strobe_i),
    .program_fetch_strobe_i(program_fetch_strobe_i),
    .mode_o(mode),
    .reserved_o(reserved)
  );

  assign prog_mode = (mode != BMSRM_MODE_USER);
  assign mode_o = mode;
  assign user_application_mode_o = !prog_mode;
  assign reserved_strap_o = reserved;
  assign serial_port_zero_prog_o = (mode == BMSRM_MODE_SERIAL);
  // Baud limit is a divisor floor; the actual figure depends on the oscillator
  assign baud_ok_o = !serial_port_zero_prog_o || (baud_div_i >= 16'(BAUD_DIV_MIN));

  assign boot_rom_enable_bit_o = hw_config_byte_zero_r[BMSRM_ROM_ENABLE_BIT];
  assign hi_hit = fetch_addr_i >= BMSRM_ROM_HI_BASE;
  assign lo_hit = fetch_addr_i < BMSRM_ROM_SIZE;
  always_comb begin
    rom_sel_o = 1'b0;
    if (prog_mode) begin
      rom_sel_o = lo_hit;
    end else if (boot_rom_enable_bit_o) begin
      rom_sel_o = hi_hit;
    end
  end
  assign rom_addr_o = fetch_addr_i[10:0] & BMSRM_ROM_OFS_MASK;
  assign cfg_read_entry_o = !prog_mode && boot_rom_enable_bit_o &&
                            (fetch_addr_i == BMSRM_CFG_READ_ENTRY);

  // Flash writes need code fetched from ROM or RAM, so a flash fetch blocks them
  assign flash_we_o = flash_we_i && (rom_sel_o || fetch_from_ram_i);
  assign cfg_we_o = cfg_we_i && prog_mode;
  assign erased_value_o = BMSRM_ERASED_BYTE;

  always_comb begin
    if (flash_addr_i < 16'(BMSRM_CFG_BYTES)) begin
      flash_sect_o = BMSRM_SEC_CONFIG;
    end else if (flash_addr_i < BMSRM_RESET_SECTOR_SIZE) begin
      flash_sect_o = BMSRM_SEC_RESET;
    end else if (flash_addr_i < PROG_MEM_SIZE) begin
      flash_sect_o = BMSRM_SEC_PROGRAM;
    end else begin
      flash_sect_o = BMSRM_SEC_DATA;
    end
  end

  always_comb begin
    hw_config_byte_zero_nxt = hw_config_byte_zero_r;
    cfg_data_nxt = cfg_rdata_i;
    if (cfg_we_o && cfg_addr_i == BMSRM_CFG0_ADDR) begin
      hw_config_byte_zero_nxt = cfg_wdata_i;
    end
    if (cfg_addr_i == BMSRM_CFG0_ADDR) begin
      cfg_data_nxt = hw_config_byte_zero_r;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hw_config_byte_zero_r <= BMSRM_CFG0_RESET;
      cfg_data_r <= BMSRM_ERASED_BYTE;
    end else begin
      hw_config_byte_zero_r <= hw_config_byte_zero_nxt;
      cfg_data_r <= cfg_data_nxt;
    end
  end
  assign cfg_read_data_o = cfg_data_r;

  chk_user_hi_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!prog_mode && boot_rom_enable_bit_o && hi_hit) |-> rom_sel_o)
    else $error("upper region missed rom");
  chk_prog_lo_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    prog_mode |-> (rom_sel_o == lo_hit))
    else $error("prog mode rom map wrong");
  chk_rom_disabled: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!prog_mode && !boot_rom_enable_bit_o) |-> !rom_sel_o)
    else $error("disabled rom selected");
  chk_cfg_locked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !prog_mode |=> $stable(hw_config_byte_zero_r))
    else $error("config changed in user mode");
  chk_flash_fetch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    flash_we_o |-> (rom_sel_o || fetch_from_ram_i))
    else $error("flash write from flash code");
  chk_serial_port: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    serial_port_zero_prog_o |-> mode == BMSRM_MODE_SERIAL && !user_application_mode_o)
    else $error("serial port mode mismatch");
  chk_reserved_fb: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reserved |-> mode == BMSRM_MODE_USER)
    else $error("reserved strap not user");
  chk_cfg_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg_addr_i == BMSRM_CFG0_ADDR |=> cfg_read_data_o == $past(hw_config_byte_zero_r))
    else $error("config read wrong");
  cov_serial: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    mode == BMSRM_MODE_SERIAL);
  cov_parallel: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    mode == BMSRM_MODE_PARALLEL && cfg_we_o);
  cov_user_rom: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg_read_entry_o);
  cov_reserved: cover property (@(posedge clk_i) disable iff (!rst_n_i) reserved);
endmodule : bmsrm_boot_map
`default_nettype wire

// *** design/bmsrm_pkg.sv ***
// Package: modes, address map and flash sections for boot mode select and ROM map
`default_nettype none
package bmsrm_pkg;
  typedef enum logic [1:0] {
    BMSRM_MODE_USER,
    BMSRM_MODE_SERIAL,
    BMSRM_MODE_PARALLEL
  } bmsrm_mode_e;
  localparam int BMSRM_ADDR_W = 16;
  localparam logic [15:0] BMSRM_ROM_HI_BASE = 16'hf800;
  localparam logic [15:0] BMSRM_ROM_SIZE = 16'h0800;
  localparam logic [10:0] BMSRM_ROM_OFS_MASK = 11'h7ff;
  localparam logic [15:0] BMSRM_CFG_READ_ENTRY = 16'hffdf;
  localparam int BMSRM_CFG_BYTES = 128;
  localparam logic [15:0] BMSRM_RESET_SECTOR_SIZE = 16'h1000;
  localparam int BMSRM_ROM_ENABLE_BIT = 4;
  localparam logic [7:0] BMSRM_CFG0_RESET = 8'hff;
  localparam logic [7:0] BMSRM_ERASED_BYTE = 8'hff;
  localparam logic [6:0] BMSRM_CFG0_ADDR = 7'h7f;
  typedef enum logic [1:0] {
    BMSRM_SEC_CONFIG,
    BMSRM_SEC_RESET,
    BMSRM_SEC_PROGRAM,
    BMSRM_SEC_DATA
  } bmsrm_sect_e;
endpackage : bmsrm_pkg
`default_nettype wire

// *** design/bmsrm_strap_latch.sv ***
// Strap sampler: samples straps on the first clock after reset release, then freezes
`timescale 1ns/1ps
`default_nettype none
module bmsrm_strap_latch (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic addr_latch_strobe_i,
  input wire logic program_fetch_strobe_i,
  output bmsrm_pkg::bmsrm_mode_e mode_o,
  output logic reserved_o
);
  import bmsrm_pkg::*;
  logic in_reset_r;
  logic in_reset_nxt;
  bmsrm_mode_e mode_r;
  bmsrm_mode_e mode_nxt;
  logic reserved_r;
  logic reserved_nxt;

  // Straps are read in the first clocked cycle after release, never at the async edge
  always_comb begin
    in_reset_nxt = 1'b0;
    mode_nxt = mode_r;
    reserved_nxt = reserved_r;
    if (in_reset_r) begin
      reserved_nxt = 1'b0;
      if (!program_fetch_strobe_i && addr_latch_strobe_i) begin
        mode_nxt = BMSRM_MODE_SERIAL;
      end else if (program_fetch_strobe_i && !addr_latch_strobe_i) begin
        mode_nxt = BMSRM_MODE_PARALLEL;
      end else if (program_fetch_strobe_i && addr_latch_strobe_i) begin
        mode_nxt = BMSRM_MODE_USER;
      end else begin
        mode_nxt = BMSRM_MODE_USER;
        reserved_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_reset_r <= 1'b1;
      mode_r <= BMSRM_MODE_USER;
      reserved_r <= 1'b0;
    end else begin
      in_reset_r <= in_reset_nxt;
      mode_r <= mode_nxt;
      reserved_r <= reserved_nxt;
    end
  end

  assign mode_o = mode_r;
  assign reserved_o = reserved_r;

  chk_mode_stable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !$past(in_reset_r) |-> mode_r == $past(mode_r))
    else $error("mode changed outside reset");
endmodule : bmsrm_strap_latch
`default_nettype wire

// *** testbench/bmsrm_strap_host.sv ***
// Host model: sets the boot straps around each reset
`timescale 1ns/1ps
`default_nettype none
module bmsrm_strap_host (
  input wire logic clk_i,
  input wire logic [1:0] sel_i,
  input wire logic bad_i,
  output logic addr_latch_strobe_o,
  output logic program_fetch_strobe_o
);
  // Sel: 0 user, 1 serial, 2 parallel, 3 both low only when bad_i allows it
  // Programming is left only by a reset with both straps high or both straps low
  always_ff @(posedge clk_i) begin
    addr_latch_strobe_o <= sel_i != 2'h2 && !(sel_i == 2'h3 && bad_i);
    program_fetch_strobe_o <= sel_i != 2'h1 && !(sel_i == 2'h3 && bad_i);
  end
endmodule : bmsrm_strap_host
`default_nettype wire

// *** testbench/tb.sv ***
// Testbench: strap decode, boot ROM map, write gating, flash sections
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bmsrm_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] sel = 2'h0;
  logic bad = 1'b0;
  logic [15:0] fa = 16'h0000;
  logic [15:0] fla = 16'h0000;
  logic [15:0] baud = 16'h0010;
  logic [6:0] ca = 7'h00;
  logic [7:0] cd = 8'h00;
  logic cwi = 1'b0;
  logic fram = 1'b0;
  logic fwi = 1'b0;
  logic als, pfs, user_application_mode, spz, rsv, rsel, ent, ebit, cwe, fwe, bok;
  bmsrm_mode_e mode;
  bmsrm_sect_e sect;
  logic [10:0] raddr;
  logic [7:0] rdata, erased;
  int fail_count = 0;
  int checked = 0;
  // Row: sel, mode, reserved flag, rom at f800, rom at 0000, user
  logic [7:0] rows [4] = '{8'h05, 8'h52, 8'ha2, 8'hcd};
  logic [17:0] secs [6] = '{18'h0007f, 18'h10080, 18'h10fff, 18'h21000, 18'h27fff, 18'h38000};
  always #50 clk_i = ~clk_i;
  bmsrm_strap_host u_host (.clk_i(clk_i), .sel_i(sel), .bad_i(bad),
    .addr_latch_strobe_o(als), .program_fetch_strobe_o(pfs));
  bmsrm_boot_map u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_latch_strobe_i(als),
    .program_fetch_strobe_i(pfs), .fetch_addr_i(fa), .fetch_from_ram_i(fram),
    .cfg_addr_i(ca), .cfg_wdata_i(cd), .cfg_we_i(cwi), .cfg_rdata_i(8'h5a),
    .flash_addr_i(fla), .flash_we_i(fwi), .baud_div_i(baud), .mode_o(mode),
    .user_application_mode_o(user_application_mode), .serial_port_zero_prog_o(spz), .reserved_strap_o(rsv),
    .rom_sel_o(rsel), .rom_addr_o(raddr), .cfg_read_entry_o(ent), .cfg_read_data_o(rdata),
    .boot_rom_enable_bit_o(ebit), .cfg_we_o(cwe), .flash_we_o(fwe), .flash_sect_o(sect),
    .baud_ok_o(bok), .erased_value_o(erased));
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task stop_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // Straps settle while reset is low, so the sample edge sees stable levels
  task boot(input logic [1:0] s, input logic b);
    @(posedge clk_i);
    {sel, bad, rst_n_i} <= {s, b, 1'b0};
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(negedge clk_i);
  endtask : boot
  task drive(input logic [15:0] f, input logic r, input logic w);
    @(posedge clk_i);
    {fa, fram, fwi} <= {f, r, w};
    @(negedge clk_i);
  endtask : drive
  task cfgw(input logic [7:0] d, input logic w, input logic [7:0] r);
    @(posedge clk_i);
    {ca, cd, cwi} <= {7'h7f, d, 1'b1};
    @(negedge clk_i);
    chk("cfg_we", cwe, w);
    @(posedge clk_i);
    cwi <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk("cfg_rd", rdata, r);
    chk("rom_en", ebit, r[4]);
  endtask : cfgw
  initial begin
    for (int i = 0; i < 4; i++) begin
      boot(rows[i][7:6], 1'b1);
      chk("mode", mode, rows[i][5:4]);
      chk("reserved", rsv, rows[i][3]);
      chk("user", user_application_mode, rows[i][0]);
      chk("serial", spz, rows[i][7:6] == 2'h1);
      drive(16'hf805, 1'b0, 1'b0);
      chk("rom_hi", rsel, rows[i][2]);
      chk("rom_addr", raddr, 16'h0005);
      drive(16'h0005, 1'b0, 1'b0);
      chk("rom_lo", rsel, rows[i][1]);
    end
    $display("test mode table done");
    boot(2'h0, 1'b0);
    chk("erased", erased, 16'h00ff);
    drive(16'hffdf, 1'b0, 1'b0);
    chk("entry", ent, 16'h0001);
    drive(16'h0100, 1'b0, 1'b1);
    chk("we_flash", fwe, 16'h0000);
    chk("entry_off", ent, 16'h0000);
    drive(16'h0100, 1'b1, 1'b1);
    chk("we_ram", fwe, 16'h0001);
    cfgw(8'hef, 1'b0, 8'hff);
    @(posedge clk_i);
    ca <= 7'h00;
    repeat (2) @(negedge clk_i);
    chk("cfg_pass", rdata, 16'h005a);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      fla <= secs[i][15:0];
      @(negedge clk_i);
      chk("section", sect, secs[i][17:16]);
    end
    $display("test user mode done");
    boot(2'h1, 1'b0);
    @(posedge clk_i);
    baud <= 16'h000f;
    @(negedge clk_i);
    chk("baud", bok, 16'h0000);
    @(posedge clk_i);
    {baud, sel} <= {16'h0010, 2'h0};
    repeat (4) @(negedge clk_i);
    chk("baud_ok", bok, 16'h0001);
    chk("mode_held", mode, 16'h0001);
    cfgw(8'hef, 1'b1, 8'hef);
    drive(16'hffdf, 1'b0, 1'b0);
    chk("entry_prog", ent, 16'h0000);
    chk("rom_top_prog", rsel, 16'h0000);
    drive(16'h0005, 1'b0, 1'b1);
    chk("we_rom", fwe, 16'h0001);
    boot(2'h0, 1'b0);
    chk("mode_exit", mode, 16'h0000);
    $display("test programming mode done");
    stop_test();
  end
  // Whole run is under a hundred cycles; this bound is generous
  initial begin
    #500000;
    fail_count++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
